// file: design/timer_ctrlb_setclr_sync_busy_flags.sv
// How it works
// RQ1: Lock bit blocks buffer-to-active copies.
// RQ2: Lock ignored while input capture enabled.
// RQ3: Unlocked: copy buffers on wrap or retrigger.
// RQ4: Direction reads one while counting down.
// RQ5: Clear address one on direction: count up.
// RQ6: Set address one on direction: count down.
// RQ7: Set and clear share one control state.
// RQ8: Command runs next prescaled tick, then zeroes.
// RQ9: Codes: none, retrigger, stop, update, fetch.
// RQ10: Set address: nonzero valid code becomes pending.
// RQ11: Slot command runs at update, flag updated.
// RQ12: Slot codes: alternate, force B, A, repeat.
// RQ13: Set address: nonzero slot code becomes pending.
// RQ14: Single run halts at wrap or stop.
// RQ15: Set address one enables single run.
// RQ16: Buffer busy flags at bits 22:16.
// RQ17: Active compare and period busy at 11:7.
// RQ18: Busy flags only for existing channels.
// RQ19: Reserved busy bits always read zero.
// RQ20: Lower busy flags bits 6:0, same behaviour.
// RQ21: Clear address cancels matching pending command.
// RQ22: Control write shows busy on next read.
// RQ23: Software polls busy before rewriting register.
`default_nettype none
`include "timer_ctrlb_defs.svh"

module timer_ctrlb_setclr_sync_busy_flags
  import timer_ctrlb_pkg::*;
#(
  parameter int CHANNELS = `MAX_CHANNELS
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire axi_req_t           axi_req,
  output axi_rsp_t                axi_rsp,
  input  wire logic               timer_tick,
  input  wire logic               wrap_event,
  input  wire logic               retrigger_event,
  input  wire logic               capture_enabled,
  input  wire logic               dual_slope_ramp,
  input  wire logic [`BUSY_W-1:0] sync_start,
  input  wire logic [`BUSY_W-1:0] sync_done,
  output logic                    count_down,
  output logic                    single_run,
  output logic                    ramp_slot_flag,
  output logic                    copy_buffers,
  output logic                    counter_halt,
  output cmd_pulse_t              cmd_pulses
);

  // ----------------------------------------------------------------
  // Busy mask: absent compare channels behave as reserved
  // ----------------------------------------------------------------
  logic [`BUSY_W-1:0] busy_mask;
  logic [`MAX_CHANNELS-1:0] chan_present;

  genvar gi;
  generate
    for (gi = 0; gi < `MAX_CHANNELS; gi++) begin : g_chan
      assign chan_present[gi] = (gi < CHANNELS); // [RQ18]
    end
  endgenerate

  always_comb begin
    busy_mask = `BUSY_FIXED_MASK; // [RQ19] [RQ20] [RQ16] [RQ17]
    busy_mask[`BUSY_CC_LSB +: `MAX_CHANNELS]  = chan_present; // [RQ18]
    busy_mask[`BUSY_CCB_LSB +: `MAX_CHANNELS] = chan_present; // [RQ18]
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t s_reg;
  state_t s_next;

  logic       awready;
  logic       wready;
  logic       arready;
  logic       wr_go;
  logic       wr_ctrl;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic       exec_cmd;
  logic       exec_update;
  logic       exec_stop;
  logic       upd_cond;
  sw_cmd_t    w_cmd;
  slot_cmd_t  w_slot;
  logic [`BUSY_W-1:0] b_start;
  logic [`BUSY_W-1:0] b_done;

  assign awready = !s_reg.aw_held && !s_reg.bvalid;
  assign wready  = !s_reg.w_held && !s_reg.bvalid;
  assign arready = !s_reg.rvalid;
  assign wr_go   = s_reg.aw_held && s_reg.w_held;
  assign wr_idx  = s_reg.aw_addr[`AXI_ADDR_W-1:2];
  assign rd_idx  = axi_req.araddr[`AXI_ADDR_W-1:2];
  assign w_cmd   = sw_cmd_t'(s_reg.w_data[`CTRL_CMD_MSB:`CTRL_CMD_LSB]);
  assign w_slot  = slot_cmd_t'(s_reg.w_data[`CTRL_SLOT_MSB:`CTRL_SLOT_LSB]);
  assign wr_ctrl = wr_go && s_reg.w_strb[0]
                   && (wr_idx == `IDX_CTRLB_SET || wr_idx == `IDX_CTRLB_CLEAR);

  always_comb begin
    s_next              = s_reg;
    s_next.pulses       = '0;
    s_next.copy_buffers = 1'b0;
    s_next.counter_halt = 1'b0;

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    if (axi_req.awvalid && awready) begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && wready) begin
      s_next.w_held = 1'b1;
      s_next.w_data = axi_req.wdata;
      s_next.w_strb = axi_req.wstrb;
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      s_next.aw_held = 1'b0;
      s_next.w_held  = 1'b0;
      s_next.bvalid  = 1'b1;
      if (wr_idx == `IDX_CTRLB_SET || wr_idx == `IDX_CTRLB_CLEAR
          || wr_idx == `IDX_SYNC_BUSY || wr_idx == `IDX_SLOT_STATUS) begin
        s_next.bresp = `RESP_OKAY;
      end else begin
        s_next.bresp = `RESP_SLVERR;
      end
    end

    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (axi_req.arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `RESP_OKAY;
      unique case (rd_idx)
        `IDX_CTRLB_SET,
        `IDX_CTRLB_CLEAR: s_next.rdata = 32'(s_reg.ctrl); // [RQ7] [RQ4]
        `IDX_SYNC_BUSY:   s_next.rdata = 32'(s_reg.busy & busy_mask); // [RQ19]
        `IDX_SLOT_STATUS: s_next.rdata = 32'(s_reg.ramp_slot_flag);
        default: begin
          s_next.rdata = '0;
          s_next.rresp = `RESP_SLVERR;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Command execution on the prescaled tick
    // ----------------------------------------------------------------
    exec_cmd    = timer_tick && (s_reg.ctrl.cmd != CMD_NONE); // [RQ8]
    exec_update = exec_cmd && (s_reg.ctrl.cmd == CMD_UPDATE);
    exec_stop   = exec_cmd && (s_reg.ctrl.cmd == CMD_STOP);
    if (exec_cmd) begin
      unique case (s_reg.ctrl.cmd) // [RQ9]
        CMD_RETRIGGER: s_next.pulses.retrigger           = 1'b1;
        CMD_STOP:      s_next.pulses.stop                = 1'b1;
        CMD_UPDATE:    s_next.pulses.update              = 1'b1;
        CMD_FETCH:     s_next.pulses.count_fetch_request = 1'b1;
        default:       s_next.pulses                     = '0;
      endcase
      s_next.ctrl.cmd = CMD_NONE; // [RQ8]
    end

    // ----------------------------------------------------------------
    // Update condition: buffer copy, ramp slot; halt on single-run wrap or stop
    // ----------------------------------------------------------------
    upd_cond = wrap_event || retrigger_event || exec_update;
    s_next.copy_buffers = upd_cond
                          && (!s_reg.ctrl.buffer_update_lock // [RQ1] [RQ3]
                              || capture_enabled); // [RQ2]
    s_next.counter_halt = (s_reg.ctrl.single_run && wrap_event) // [RQ14]
                          || exec_stop;
    if (upd_cond && dual_slope_ramp) begin
      unique case (s_reg.ctrl.ramp_slot_command) // [RQ11] [RQ12]
        SLOT_ALTERNATE: s_next.ramp_slot_flag = !s_reg.ramp_slot_flag;
        SLOT_FORCE_B:   s_next.ramp_slot_flag = 1'b1;
        SLOT_FORCE_A:   s_next.ramp_slot_flag = 1'b0;
        SLOT_REPEAT:    s_next.ramp_slot_flag = s_reg.ramp_slot_flag;
      endcase
      s_next.ctrl.ramp_slot_command = SLOT_ALTERNATE; // [RQ11]
    end

    // ----------------------------------------------------------------
    // Software set/clear; applied last so a new command wins
    // ----------------------------------------------------------------
    if (wr_ctrl && wr_idx == `IDX_CTRLB_SET) begin
      if (s_reg.w_data[`CTRL_DIR_BIT]) begin
        s_next.ctrl.dir = 1'b1; // [RQ6]
      end
      if (s_reg.w_data[`CTRL_LOCK_BIT]) begin
        s_next.ctrl.buffer_update_lock = 1'b1;
      end
      if (s_reg.w_data[`CTRL_SINGLE_BIT]) begin
        s_next.ctrl.single_run = 1'b1; // [RQ15]
      end
      if (w_slot != SLOT_ALTERNATE) begin
        s_next.ctrl.ramp_slot_command = w_slot; // [RQ13]
      end
      // Reserved codes are dropped rather than left pending
      if (w_cmd != CMD_NONE && w_cmd <= CMD_FETCH) begin
        s_next.ctrl.cmd = w_cmd; // [RQ10]
      end
    end
    if (wr_ctrl && wr_idx == `IDX_CTRLB_CLEAR) begin
      if (s_reg.w_data[`CTRL_DIR_BIT]) begin
        s_next.ctrl.dir = 1'b0; // [RQ5]
      end
      if (s_reg.w_data[`CTRL_LOCK_BIT]) begin
        s_next.ctrl.buffer_update_lock = 1'b0;
      end
      if (s_reg.w_data[`CTRL_SINGLE_BIT]) begin
        s_next.ctrl.single_run = 1'b0;
      end
      if (w_slot != SLOT_ALTERNATE && w_slot == s_reg.ctrl.ramp_slot_command) begin
        s_next.ctrl.ramp_slot_command = SLOT_ALTERNATE; // [RQ21]
      end
      if (w_cmd != CMD_NONE && w_cmd == s_reg.ctrl.cmd) begin
        s_next.ctrl.cmd = CMD_NONE; // [RQ21]
      end
    end

    // ----------------------------------------------------------------
    // Busy flags; a start in the completion cycle keeps the flag set
    // ----------------------------------------------------------------
    b_start = sync_start;
    b_done  = sync_done;
    b_start[`BUSY_CTRLB_BIT] = wr_ctrl; // [RQ22]
    b_done[`BUSY_CTRLB_BIT]  = (s_reg.ctrlb_wait == 4'h1);
    if (wr_ctrl) begin
      s_next.ctrlb_wait = `CTRLB_SYNC_CYCLES;
    end else if (s_reg.ctrlb_wait != 4'h0) begin
      s_next.ctrlb_wait = s_reg.ctrlb_wait - 4'h1;
    end
    s_next.busy = ((s_reg.busy & ~b_done) | b_start) & busy_mask; // [RQ16] [RQ17] [RQ20]
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_reg      <= '0;
      s_reg.ctrl <= ctrl_t'(`CTRL_RESET);
      s_reg.busy <= `BUSY_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    axi_rsp.awready = awready;
    axi_rsp.wready  = wready;
    axi_rsp.bvalid  = s_reg.bvalid;
    axi_rsp.bresp   = s_reg.bresp;
    axi_rsp.arready = arready;
    axi_rsp.rvalid  = s_reg.rvalid;
    axi_rsp.rdata   = s_reg.rdata;
    axi_rsp.rresp   = s_reg.rresp;
  end

  assign count_down     = s_reg.ctrl.dir; // [RQ4]
  assign single_run     = s_reg.ctrl.single_run;
  assign ramp_slot_flag = s_reg.ramp_slot_flag;
  assign copy_buffers   = s_reg.copy_buffers;
  assign counter_halt   = s_reg.counter_halt;
  assign cmd_pulses     = s_reg.pulses;

endmodule

`default_nettype wire

// file: design/timer_ctrlb_defs.svh
`ifndef TIMER_CTRLB_DEFS_SVH
`define TIMER_CTRLB_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CTRLB_CLEAR   6'h04
`define IDX_CTRLB_SET     6'h05
`define IDX_SYNC_BUSY     6'h08
`define IDX_SLOT_STATUS   6'h0a

// ----------------------------------------------------------------
// Bus widths and answers
// ----------------------------------------------------------------
`define AXI_ADDR_W        8
`define AXI_DATA_W        32
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------
`define CTRL_DIR_BIT      0
`define CTRL_LOCK_BIT     1
`define CTRL_SINGLE_BIT   2
`define CTRL_SLOT_LSB     3
`define CTRL_SLOT_MSB     4
`define CTRL_CMD_LSB      5
`define CTRL_CMD_MSB      7
`define CTRL_RESET        8'h00

// ----------------------------------------------------------------
// Busy flag layout
// ----------------------------------------------------------------
`define BUSY_W            23
`define BUSY_CCB_LSB      19
`define BUSY_CC_LSB       8
`define BUSY_CTRLB_BIT    2
`define BUSY_RESET        23'h000000
`define BUSY_FIXED_MASK   23'h0700ff
`define MAX_CHANNELS      4

// ----------------------------------------------------------------
// Control-B crossing latency, in clock cycles
// ----------------------------------------------------------------
`define CTRLB_SYNC_CYCLES 4'h4

`endif

// file: design/timer_ctrlb_pkg.sv
`default_nettype none
`include "timer_ctrlb_defs.svh"

package timer_ctrlb_pkg;

  typedef enum logic [2:0] {
    CMD_NONE      = 3'h0,
    CMD_RETRIGGER = 3'h1,
    CMD_STOP      = 3'h2,
    CMD_UPDATE    = 3'h3,
    CMD_FETCH     = 3'h4
  } sw_cmd_t;

  typedef enum logic [1:0] {
    SLOT_ALTERNATE = 2'h0,
    SLOT_FORCE_B   = 2'h1,
    SLOT_FORCE_A   = 2'h2,
    SLOT_REPEAT    = 2'h3
  } slot_cmd_t;

  typedef struct packed {
    sw_cmd_t   cmd;
    slot_cmd_t ramp_slot_command;
    logic      single_run;
    logic      buffer_update_lock;
    logic      dir;
  } ctrl_t;

  typedef struct packed {
    logic                   awvalid;
    logic [`AXI_ADDR_W-1:0] awaddr;
    logic                   wvalid;
    logic [`AXI_DATA_W-1:0] wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`AXI_ADDR_W-1:0] araddr;
    logic                   rready;
  } axi_req_t;

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [`AXI_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic retrigger;
    logic stop;
    logic update;
    logic count_fetch_request;
  } cmd_pulse_t;

  typedef struct packed {
    ctrl_t                  ctrl;
    logic                   aw_held;
    logic [`AXI_ADDR_W-1:0] aw_addr;
    logic                   w_held;
    logic [`AXI_DATA_W-1:0] w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [`AXI_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
    logic [`BUSY_W-1:0]     busy;
    logic [3:0]             ctrlb_wait;
    logic                   ramp_slot_flag;
    cmd_pulse_t             pulses;
    logic                   copy_buffers;
    logic                   counter_halt;
  } state_t;

endpackage

`default_nettype wire

// file: tb/timer_ctrlb_setclr_sync_busy_flags_asserts.sv
`default_nettype none
`include "timer_ctrlb_defs.svh"

// ----
// Port checker
// ----
module timer_ctrlb_asserts
  import timer_ctrlb_pkg::*;
#(
  parameter int CHANNELS = `MAX_CHANNELS
) (
  input wire logic               clock,
  input wire logic               arst_n,
  input wire axi_req_t           axi_req,
  input wire axi_rsp_t           axi_rsp,
  input wire logic               timer_tick,
  input wire logic               wrap_event,
  input wire logic               retrigger_event,
  input wire logic               capture_enabled,
  input wire logic               dual_slope_ramp,
  input wire logic [`BUSY_W-1:0] sync_start,
  input wire logic [`BUSY_W-1:0] sync_done,
  input wire logic               count_down,
  input wire logic               single_run,
  input wire logic               ramp_slot_flag,
  input wire logic               copy_buffers,
  input wire logic               counter_halt,
  input wire cmd_pulse_t         cmd_pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  AST_HALT_WRAP: assert property (single_run && wrap_event |=> counter_halt)
    else $error("no halt after wrap in single run");
  AST_HALT_CAUSE: assert property (counter_halt |-> $past(single_run && wrap_event) || cmd_pulses.stop)
    else $error("halt without cause");
  AST_STOP_HALTS: assert property (cmd_pulses.stop |-> counter_halt)
    else $error("stop command without halt");
  AST_COPY_CAPTURE: assert property ((wrap_event || retrigger_event) && capture_enabled |=> copy_buffers)
    else $error("copy missing while capture enabled");
  AST_COPY_CAUSE: assert property (copy_buffers |-> $past(wrap_event || retrigger_event) || cmd_pulses.update)
    else $error("copy without update condition");
  AST_PULSE_TICK: assert property (cmd_pulses != 4'h0 |-> $past(timer_tick))
    else $error("command ran without a timer tick");
  AST_RESERVED_ZERO: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:23] == 9'h0 && axi_rsp.rdata[15:12] == 4'h0)
    else $error("reserved read bits not zero");
  AST_DIR_BY_WRITE: assert property ($changed(count_down) |-> $rose(axi_rsp.bvalid))
    else $error("direction changed without a write");
  AST_SINGLE_BY_WRITE: assert property ($changed(single_run) |-> $rose(axi_rsp.bvalid))
    else $error("single run changed without a write");
  AST_SLOT_CAUSE: assert property ($changed(ramp_slot_flag) |-> $past(dual_slope_ramp && (wrap_event || retrigger_event)) || cmd_pulses.update)
    else $error("slot flag moved without update");

  cover property (counter_halt);
  cover property (copy_buffers);
  cover property ($rose(ramp_slot_flag));
endmodule

bind timer_ctrlb_setclr_sync_busy_flags timer_ctrlb_asserts #(.CHANNELS(CHANNELS)) u_chk (
  .clock(clock), .arst_n(arst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .timer_tick(timer_tick), .wrap_event(wrap_event), .retrigger_event(retrigger_event),
  .capture_enabled(capture_enabled), .dual_slope_ramp(dual_slope_ramp),
  .sync_start(sync_start), .sync_done(sync_done), .count_down(count_down),
  .single_run(single_run), .ramp_slot_flag(ramp_slot_flag), .copy_buffers(copy_buffers),
  .counter_halt(counter_halt), .cmd_pulses(cmd_pulses)
);

`default_nettype wire

// file: tb/timer_ctrlb_setclr_sync_busy_flags_bench.sv
`default_nettype none
`include "timer_ctrlb_defs.svh"

module timer_ctrlb_setclr_sync_busy_flags_bench
  import timer_ctrlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock, arst_n, cap, dual;
  logic [2:0]         ev;
  logic [`BUSY_W-1:0] s_start, s_done;
  axi_req_t           req;
  axi_rsp_t           rsp;
  logic               count_down, single_run, ramp_slot_flag, copy_buffers, counter_halt;
  cmd_pulse_t         pulses;
  logic [31:0]        d;
  logic [1:0]         r;
  int                 errors, check_count, i;

  // Three channels so the absent-channel masking is exercised
  timer_ctrlb_setclr_sync_busy_flags #(.CHANNELS(3)) u_dut (
    .clock(clock), .arst_n(arst_n), .axi_req(req), .axi_rsp(rsp),
    .timer_tick(ev[2]), .wrap_event(ev[1]), .retrigger_event(ev[0]),
    .capture_enabled(cap), .dual_slope_ramp(dual), .sync_start(s_start),
    .sync_done(s_done), .count_down(count_down), .single_run(single_run),
    .ramp_slot_flag(ramp_slot_flag), .copy_buffers(copy_buffers),
    .counter_halt(counter_halt), .cmd_pulses(pulses)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----
  // Bus and timer tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge clock);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Software waits out the control crossing before trusting new values
  task automatic poll_idle;
    rd(8'h20);
    while (d[`BUSY_CTRLB_BIT] !== 1'b0) begin
      rd(8'h20);
    end
  endtask

  // One-cycle pulses; outputs are looked at just after they register
  task automatic fire(input logic [2:0] e, input logic [22:0] s, input logic [22:0] c);
    @(posedge clock);
    ev      <= e;
    s_start <= s;
    s_done  <= c;
    @(posedge clock);
    ev      <= 3'h0;
    s_start <= '0;
    s_done  <= '0;
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done;
  end

  // ----
  // Tests
  // ----
  initial begin
    arst_n = 1'b0;
    req = '0;
    ev = 3'h0;
    cap = 1'b0;
    dual = 1'b0;
    s_start = '0;
    s_done = '0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'h14); chk(d, 32'h0);
    rd(8'h20); chk(d, 32'h0);
    rd(8'h30); chk(32'(r), 32'(`RESP_SLVERR));
    wr(8'h30, 32'h0); chk(32'(r), 32'(`RESP_SLVERR));
    $display("reset test done");
    wr(8'h14, 32'h1); rd(8'h20); chk(d, 32'h4);
    poll_idle; chk(d, 32'h0);
    rd(8'h10); chk(d, 32'h1);
    chk(32'(count_down), 32'h1);
    wr(8'h14, 32'h0); wr(8'h10, 32'h0); chk(32'(count_down), 32'h1);
    wr(8'h10, 32'h1); chk(32'(count_down), 32'h0);
    chk(32'(r), 32'(`RESP_OKAY));
    $display("direction test done");
    wr(8'h14, 32'h4); chk(32'(single_run), 32'h1);
    fire(3'b010, '0, '0); chk(32'(counter_halt), 32'h1);
    wr(8'h10, 32'h4); fire(3'b010, '0, '0); chk(32'(counter_halt), 32'h0);
    $display("single run test done");
    wr(8'h14, 32'h2); fire(3'b010, '0, '0); chk(32'(copy_buffers), 32'h0);
    @(posedge clock);
    cap <= 1'b1;
    fire(3'b010, '0, '0); chk(32'(copy_buffers), 32'h1);
    @(posedge clock);
    cap <= 1'b0;
    wr(8'h10, 32'h2); fire(3'b001, '0, '0); chk(32'(copy_buffers), 32'h1);
    $display("lock test done");
    for (i = 1; i < 5; i++) begin
      wr(8'h14, 32'(i << 5)); rd(8'h10); chk(d, 32'(i << 5));
      fire(3'b100, '0, '0); chk(32'(pulses), 32'(4'h8 >> (i - 1)));
      rd(8'h14); chk(d, 32'h0);
    end
    wr(8'h14, 32'ha0); rd(8'h14); chk(d, 32'h0);
    wr(8'h14, 32'h20); wr(8'h14, 32'h0); rd(8'h14); chk(d, 32'h20);
    wr(8'h10, 32'h20); rd(8'h14); chk(d, 32'h0);
    $display("command test done");
    dual <= 1'b1;
    for (i = 1; i < 4; i++) begin
      wr(8'h14, 32'(i << 3)); fire(3'b010, '0, '0); chk(32'(ramp_slot_flag), 32'(i == 1));
      rd(8'h14); chk(d, 32'h0);
    end
    fire(3'b010, '0, '0); chk(32'(ramp_slot_flag), 32'h1);
    rd(8'h28); chk(d, 32'h1);
    $display("ramp slot test done");
    fire(3'b000, '1, '0); rd(8'h20); chk(d, 32'h3f07fb);
    fire(3'b000, '0, '1); rd(8'h20); chk(d, 32'h0);
    $display("busy test done");
    test_done;
  end
endmodule

`default_nettype wire
